//--- arp_adc_post.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
// How it works
// - accumulate selected sample count, store divided average
// - divide by automatic shift plus extra shift
// - ready flag only after complete average
// - averaged rate equals raw rate over count
// - oversample four-to-n samples, shift by n
// - compare result against lower and upper thresholds
// - signed thresholds differential, unsigned single-ended
// - only threshold bits of selected resolution count
// - window match sets its interrupt flag
// - subtract offset, multiply by gain when corrected
// - correction adds thirteen cycles latency, in free-run to the first average only
// - three flags: ready, window match, overrun
// - enable set and clear by writing ones
// - request while flag set and enabled
// - writing one clears a flag
// - ready and match events when enabled
// - enabled input events start or flush
// - any routed event triggers the action
// - resolution resets to twelve bits
// - sums beyond sixteen samples shifted to fit
module arp_adc_post
  import arp_pkg::*;
#(
  parameter int NUM_EVT = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input arp_sample_t sample_in,
  input wire logic [NUM_EVT-1:0] start_evt,
  input wire logic [NUM_EVT-1:0] flush_evt,
  output logic conv_req,
  output logic result_ready_evt,
  output logic window_match_evt,
  output logic irq
);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [3:0] snum_q; // sample count code
  logic [2:0] division_shift_code_q; // division shift code
  logic diff_q; // differential input
  logic free_q; // free-running
  logic corr_en_q; // correction enable
  logic [1:0] resolution_select_q; // resolution select
  logic [2:0] window_mode_select_q; // window mode select
  logic [5:0] evctl_q; // event control bits
  logic [15:0] window_lower_threshold_q;
  logic [15:0] window_upper_threshold_q;
  logic signed [11:0] offs_q; // offset correction value
  logic [11:0] gain_q; // gain correction value, 1.11 format
  logic [2:0] inten_q; // interrupt enables
  logic [2:0] flag_q; // interrupt flags
  logic [15:0] result_q;
  logic unread_q; // result not read yet

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  arp_state_t state_q;
  logic signed [22:0] acc_q; // partial sum, 22 bits plus sign
  logic [9:0] cnt_q; // samples taken so far
  logic signed [15:0] fin_q; // average held during correction
  logic [3:0] lat_q; // correction latency counter
  logic first_q; // correction latency already paid

  // strobe decode
  logic wr_trig;
  assign wr_trig = reg_wr && (reg_addr == ARP_OFS_SWTRIG);

  // start and flush requests, software or any enabled event
  logic go;
  logic flush;
  assign go = (wr_trig && reg_wdata[ARP_SW_START]) ||
              (evctl_q[ARP_EV_START_EI] && (|start_evt));
  assign flush = (wr_trig && reg_wdata[ARP_SW_FLUSH]) ||
                 (evctl_q[ARP_EV_FLUSH_EI] && (|flush_evt));

  // ---------------------------------------------------------------
  // accumulation arithmetic
  // ---------------------------------------------------------------
  logic snum_ok; // reserved codes behave as one sample
  logic [10:0] m_full;
  logic [9:0] m_last;
  logic last;
  assign snum_ok = (snum_q <= ARP_SNUM_MAX);
  assign m_full = snum_ok ? (11'h001 << snum_q) : 11'h001;
  assign m_last = 10'(m_full - 11'h001);
  assign last = (cnt_q == m_last);

  // sample widened; low bits dropped in 10 and 8 bit modes
  logic signed [22:0] samp_ext;
  logic [2:0] res_drop;
  always_comb begin
    // lower resolutions simply discard low sample bits
    case (resolution_select_q)
      ARP_RES_10: res_drop = 3'h2;
      ARP_RES_8: res_drop = 3'h4;
      default: res_drop = 3'h0;
    endcase
    if (diff_q) begin
      samp_ext = 23'({{11{sample_in.data[11]}}, sample_in.data});
    end else begin
      samp_ext = {11'h000, sample_in.data};
    end
    samp_ext = samp_ext >>> res_drop;
  end

  // automatic shift beyond sixteen samples plus extra shift
  logic [3:0] auto_sh;
  logic [3:0] tot_sh;
  logic signed [22:0] acc_d;
  logic signed [22:0] acc_sh;
  logic signed [15:0] fin;
  assign auto_sh = (snum_ok && snum_q > ARP_SNUM_AUTO) ?
                   (snum_q - ARP_SNUM_AUTO) : 4'h0;
  assign tot_sh = snum_ok ? (auto_sh + {1'b0, division_shift_code_q}) : 4'h0;
  assign acc_d = acc_q + samp_ext;
  assign acc_sh = acc_d >>> tot_sh;
  assign fin = acc_sh[15:0];

  // ---------------------------------------------------------------
  // offset and gain correction
  // ---------------------------------------------------------------
  logic signed [15:0] src;
  logic signed [16:0] minus_offs;
  logic signed [29:0] prod;
  logic [15:0] new_res;
  assign src = (state_q == ARP_ST_CORR) ? fin_q : fin;
  assign minus_offs = 17'(src) - 17'(offs_q);
  assign prod = 30'(minus_offs) * 30'($signed({1'b0, gain_q}));
  // correction off: raw average goes straight through
  assign new_res = corr_en_q ?
    prod[ARP_GAIN_FRAC+15:ARP_GAIN_FRAC] : src;

  // latency paid every time in single mode, once in free-run
  logic need_corr;
  assign need_corr = corr_en_q && (!free_q || !first_q);

  // one average completes: from the last sample or after latency
  logic done_run;
  logic done_corr;
  logic res_wr;
  assign done_run = (state_q == ARP_ST_RUN) && sample_in.valid && last;
  assign done_corr = (state_q == ARP_ST_CORR) &&
                     (lat_q == ARP_CORR_LAT - 4'h1);
  assign res_wr = !flush &&
    ((done_run && !need_corr) || done_corr);

  // ---------------------------------------------------------------
  // window monitor
  // ---------------------------------------------------------------
  // keep resolution bits; in differential the top kept bit is sign
  function automatic logic [15:0] thr_fit(input logic [15:0] v,
                                          input logic [1:0] rs,
                                          input logic sgn);
    logic [15:0] r;
    r = v;
    case (rs)
      ARP_RES_8: r = {(sgn ? {8{v[7]}} : 8'h00), v[7:0]};
      ARP_RES_10: r = {(sgn ? {6{v[9]}} : 6'h00), v[9:0]};
      ARP_RES_12: r = {(sgn ? {4{v[11]}} : 4'h0), v[11:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  // signed or unsigned ordering depending on input mode
  function automatic logic is_gt(input logic [15:0] a,
                                 input logic [15:0] b,
                                 input logic sgn);
    logic g;
    g = sgn ? ($signed(a) > $signed(b)) : (a > b);
    return g;
  endfunction

  logic [15:0] lt_fit;
  logic [15:0] ut_fit;
  logic above;
  logic below;
  logic wm_hit;
  assign lt_fit = thr_fit(window_lower_threshold_q, resolution_select_q, diff_q);
  assign ut_fit = thr_fit(window_upper_threshold_q, resolution_select_q, diff_q);
  assign above = is_gt(new_res, lt_fit, diff_q);
  assign below = is_gt(ut_fit, new_res, diff_q);
  always_comb begin
    // criterion per window mode
    case (window_mode_select_q)
      ARP_WM_ABOVE: wm_hit = above;
      ARP_WM_BELOW: wm_hit = below;
      ARP_WM_INSIDE: wm_hit = above && below;
      ARP_WM_OUTSIDE: wm_hit = !(above && below);
      default: wm_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // flush outranks every other move
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ARP_ST_IDLE;
      acc_q <= '0;
      cnt_q <= '0;
      fin_q <= '0;
      lat_q <= '0;
      first_q <= 1'b0;
    end else if (flush) begin
      state_q <= ARP_ST_IDLE;
      acc_q <= '0;
      cnt_q <= '0;
      lat_q <= '0;
      first_q <= 1'b0;
    end else begin
      case (state_q)
        ARP_ST_IDLE: begin
          // wait for a trigger
          if (go) begin
            state_q <= ARP_ST_RUN;
            acc_q <= '0;
            cnt_q <= '0;
            first_q <= 1'b0;
          end
        end
        ARP_ST_RUN: begin
          if (sample_in.valid && last) begin
            // sum complete; next average starts from zero
            acc_q <= '0;
            cnt_q <= '0;
            fin_q <= fin;
            if (need_corr) begin
              state_q <= ARP_ST_CORR;
              lat_q <= '0;
            end else if (!free_q) begin
              state_q <= ARP_ST_IDLE;
            end
          end else if (sample_in.valid) begin
            acc_q <= acc_d;
            cnt_q <= cnt_q + 10'h001;
          end
        end
        ARP_ST_CORR: begin
          // correction pipeline wait
          lat_q <= lat_q + 4'h1;
          if (done_corr) begin
            first_q <= 1'b1;
            state_q <= free_q ? ARP_ST_RUN : ARP_ST_IDLE;
          end
        end
        default: state_q <= ARP_ST_IDLE;
      endcase
    end
  end

  // conversion request to the front end, one pulse per sample
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_req <= 1'b0;
    end else begin
      conv_req <= !flush &&
        ((state_q == ARP_ST_IDLE && go) ||
         (state_q == ARP_ST_RUN && sample_in.valid &&
          (!last || (!need_corr && free_q))) ||
         (done_corr && free_q));
    end
  end

  // ---------------------------------------------------------------
  // result, overrun tracking and events
  // ---------------------------------------------------------------
  // a new result in the same cycle as a read stays unread
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_q <= '0;
      unread_q <= 1'b0;
    end else begin
      if (res_wr) begin
        result_q <= new_res;
        unread_q <= 1'b1;
      end else if (reg_rd && reg_addr == ARP_OFS_RESULT) begin
        unread_q <= 1'b0;
      end
    end
  end

  // output events, gated by their enables
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_ready_evt <= 1'b0;
      window_match_evt <= 1'b0;
    end else begin
      result_ready_evt <= res_wr && evctl_q[ARP_EV_RR_EO];
      window_match_evt <= res_wr && wm_hit &&
                          evctl_q[ARP_EV_WM_EO];
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags and request
  // ---------------------------------------------------------------
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  always_comb begin
    flag_set = '0;
    flag_set[ARP_IF_RR] = res_wr;
    flag_set[ARP_IF_OVR] = res_wr && unread_q;
    flag_set[ARP_IF_WM] = res_wr && wm_hit;
    flag_clr = (reg_wr && reg_addr == ARP_OFS_IFLAG) ?
               reg_wdata[2:0] : 3'h0;
  end

  // set beats clear so no event is lost
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // request lags the flag by one cycle, it comes from a flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_q & inten_q);
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snum_q <= '0;
      division_shift_code_q <= '0;
      diff_q <= 1'b0;
      free_q <= 1'b0;
      corr_en_q <= 1'b0;
      resolution_select_q <= ARP_RST_RES;
      window_mode_select_q <= ARP_WM_OFF;
      evctl_q <= '0;
      window_lower_threshold_q <= '0;
      window_upper_threshold_q <= '0;
      offs_q <= ARP_RST_OFFS;
      gain_q <= ARP_RST_GAIN;
      inten_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ARP_OFS_AVG: begin
          snum_q <= reg_wdata[ARP_AVG_SNUM_LSB +: 4];
          division_shift_code_q <= reg_wdata[ARP_AVG_ADJ_LSB +: 3];
        end
        ARP_OFS_SECOND_CONTROL: begin
          diff_q <= reg_wdata[ARP_CB_DIFF];
          free_q <= reg_wdata[ARP_CB_FREE];
          corr_en_q <= reg_wdata[ARP_CB_CORR];
          resolution_select_q <= reg_wdata[ARP_CB_RES_LSB +: 2];
        end
        ARP_OFS_WIN: window_mode_select_q <= reg_wdata[2:0];
        ARP_OFS_EVENT_CONTROL: evctl_q <= reg_wdata[5:0];
        ARP_OFS_WINDOW_LOWER_THRESHOLD: window_lower_threshold_q <= reg_wdata;
        ARP_OFS_WINDOW_UPPER_THRESHOLD: window_upper_threshold_q <= reg_wdata;
        ARP_OFS_OFFS: offs_q <= reg_wdata[11:0];
        ARP_OFS_GAIN: gain_q <= reg_wdata[11:0];
        ARP_OFS_IENSET: inten_q <= inten_q | reg_wdata[2:0];
        ARP_OFS_IENCLR: inten_q <= inten_q & ~reg_wdata[2:0];
        default: ; // other offsets hold no writable state
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads, data valid only in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        ARP_OFS_AVG: reg_rdata <= {9'h000, division_shift_code_q, snum_q};
        ARP_OFS_SECOND_CONTROL: reg_rdata <= {10'h000, resolution_select_q, corr_en_q,
                                     free_q, 1'b0, diff_q};
        ARP_OFS_WIN: reg_rdata <= {13'h0000, window_mode_select_q};
        ARP_OFS_EVENT_CONTROL: reg_rdata <= {10'h000, evctl_q};
        ARP_OFS_IENSET: reg_rdata <= {13'h0000, inten_q};
        ARP_OFS_IENCLR: reg_rdata <= {13'h0000, inten_q};
        ARP_OFS_IFLAG: reg_rdata <= {13'h0000, flag_q};
        ARP_OFS_RESULT: reg_rdata <= result_q;
        ARP_OFS_WINDOW_LOWER_THRESHOLD: reg_rdata <= window_lower_threshold_q;
        ARP_OFS_WINDOW_UPPER_THRESHOLD: reg_rdata <= window_upper_threshold_q;
        ARP_OFS_OFFS: reg_rdata <= {4'h0, offs_q};
        ARP_OFS_GAIN: reg_rdata <= {4'h0, gain_q};
        default: reg_rdata <= '0; // unmapped reads zero
      endcase
    end
  end

endmodule

//--- arp_adc_post_checker.sv
`timescale 1ns/1ps
module arp_adc_post_checker
  import arp_pkg::*;
#(
  parameter int NUM_EVT = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input arp_sample_t sample_in,
  input wire logic [NUM_EVT-1:0] start_evt,
  input wire logic [NUM_EVT-1:0] flush_evt,
  input wire logic conv_req,
  input wire logic result_ready_evt,
  input wire logic window_match_evt,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------
  // shadow of the configuration seen on the bus
  // ------------------------------------------------
  logic corr_q, free_q, rr_eo_q, wm_eo_q; // mirrored bits
  logic [3:0] code_q; // mirrored sample count code
  // follows writes only; reads cannot change configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {corr_q, free_q, rr_eo_q, wm_eo_q, code_q} <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ARP_OFS_SECOND_CONTROL) begin
        corr_q <= reg_wdata[ARP_CB_CORR];
        free_q <= reg_wdata[ARP_CB_FREE];
      end
      if (reg_addr == ARP_OFS_AVG) begin
        code_q <= reg_wdata[3:0];
      end
      if (reg_addr == ARP_OFS_EVENT_CONTROL) begin
        rr_eo_q <= reg_wdata[ARP_EV_RR_EO];
        wm_eo_q <= reg_wdata[ARP_EV_WM_EO];
      end
    end
  end
  // a single-sample result in single mode with its event shown
  wire logic one_smp = sample_in.valid && code_q == 4'h0 && !free_q
    && rr_eo_q;
  sequence s_plain_done;
    ##[1:2] result_ready_evt;
  endsequence
  sequence s_corr_wait;
    ##1 (!result_ready_evt) [*8] ##[6:7] result_ready_evt;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  AST_RR_PULSE: assert property (result_ready_evt |=> !result_ready_evt)
    else $error("ready event longer than one cycle");
  AST_CONV_PULSE: assert property (conv_req |=> !conv_req)
    else $error("conversion request longer than one cycle");
  AST_RR_GATED: assert property (result_ready_evt |-> rr_eo_q || $past(rr_eo_q))
    else $error("ready event while its output is disabled");
  AST_WM_GATED: assert property (window_match_evt |-> wm_eo_q || $past(wm_eo_q))
    else $error("match event while its output is disabled");
  AST_IRQ_OFF: assert property (reg_wr && reg_addr == ARP_OFS_IENCLR
    && reg_wdata[2:0] == 3'h7 |=> ##1 !irq)
    else $error("request stays after all enables cleared");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(reg_wr, 2) &&
    ($past(reg_addr, 2) == ARP_OFS_IFLAG || $past(reg_addr, 2) == ARP_OFS_IENCLR))
    else $error("request dropped without clear or disable");
  AST_FLUSH_QUIET: assert property (reg_wr && reg_addr == ARP_OFS_SWTRIG
    && reg_wdata[ARP_SW_FLUSH] |-> ##3 (!conv_req && !result_ready_evt) [*3])
    else $error("activity after flush");
  AST_PLAIN_LAT: assert property (one_smp && !corr_q |-> s_plain_done)
    else $error("uncorrected result late");
  AST_CORR_LAT: assert property (one_smp && corr_q |-> s_corr_wait)
    else $error("corrected result not thirteen cycles later");
endmodule
bind arp_adc_post arp_adc_post_checker #(.NUM_EVT(NUM_EVT)) arp_adc_post_checker_i (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_in(sample_in), .start_evt(start_evt), .flush_evt(flush_evt),
  .conv_req(conv_req), .result_ready_evt(result_ready_evt),
  .window_match_evt(window_match_evt), .irq(irq));

//--- arp_front_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// analog front end stand-in
// ------------------------------------------------
module arp_front_model
  import arp_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic conv_req,
  input wire logic [11:0] val,
  output arp_sample_t sample_in
);
  int cnt_q; // cycles left to the sample, 0 when idle
  // one sample per request, after a fixed conversion time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 0;
      sample_in <= '0;
    end else begin
      sample_in.valid <= (cnt_q == 1);
      // stale data toggles so it never looks like a held value
      sample_in.data <= (cnt_q == 1) ? val : ~sample_in.data;
      if (conv_req) begin
        cnt_q <= DLY;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

//--- arp_pkg.sv
package arp_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses on the plain port)
  // ---------------------------------------------------------------
  localparam logic [7:0] ARP_OFS_AVG = 8'h02;
  localparam logic [7:0] ARP_OFS_SECOND_CONTROL = 8'h04;
  localparam logic [7:0] ARP_OFS_WIN = 8'h08;
  localparam logic [7:0] ARP_OFS_SWTRIG = 8'h0C;
  localparam logic [7:0] ARP_OFS_EVENT_CONTROL = 8'h14;
  localparam logic [7:0] ARP_OFS_IENCLR = 8'h16;
  localparam logic [7:0] ARP_OFS_IENSET = 8'h17;
  localparam logic [7:0] ARP_OFS_IFLAG = 8'h18;
  localparam logic [7:0] ARP_OFS_RESULT = 8'h1A;
  localparam logic [7:0] ARP_OFS_WINDOW_LOWER_THRESHOLD = 8'h1C;
  localparam logic [7:0] ARP_OFS_WINDOW_UPPER_THRESHOLD = 8'h20;
  localparam logic [7:0] ARP_OFS_OFFS = 8'h24;
  localparam logic [7:0] ARP_OFS_GAIN = 8'h26;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ARP_AVG_SNUM_LSB = 0;
  localparam int ARP_AVG_ADJ_LSB = 4;
  localparam int ARP_CB_DIFF = 0;
  localparam int ARP_CB_FREE = 2;
  localparam int ARP_CB_CORR = 3;
  localparam int ARP_CB_RES_LSB = 4;
  localparam int ARP_SW_FLUSH = 0;
  localparam int ARP_SW_START = 1;
  localparam int ARP_EV_START_EI = 0;
  localparam int ARP_EV_FLUSH_EI = 1;
  localparam int ARP_EV_RR_EO = 4;
  localparam int ARP_EV_WM_EO = 5;
  localparam int ARP_IF_RR = 0;
  localparam int ARP_IF_OVR = 1;
  localparam int ARP_IF_WM = 2;

  // ---------------------------------------------------------------
  // codes, reset values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] ARP_SNUM_MAX = 4'hA;
  localparam logic [3:0] ARP_SNUM_AUTO = 4'h4;
  localparam logic [1:0] ARP_RES_12 = 2'h0;
  localparam logic [1:0] ARP_RES_16 = 2'h1;
  localparam logic [1:0] ARP_RES_10 = 2'h2;
  localparam logic [1:0] ARP_RES_8 = 2'h3;
  localparam logic [1:0] ARP_RST_RES = ARP_RES_12;
  localparam logic [11:0] ARP_RST_GAIN = 12'h800;
  localparam logic [11:0] ARP_RST_OFFS = 12'h000;
  localparam int ARP_GAIN_FRAC = 11;
  localparam logic [3:0] ARP_CORR_LAT = 4'hD;
  localparam logic [2:0] ARP_WM_OFF = 3'h0;
  localparam logic [2:0] ARP_WM_ABOVE = 3'h1;
  localparam logic [2:0] ARP_WM_BELOW = 3'h2;
  localparam logic [2:0] ARP_WM_INSIDE = 3'h3;
  localparam logic [2:0] ARP_WM_OUTSIDE = 3'h4;

  // one raw conversion from the analog front end
  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } arp_sample_t;

  // sequencer states
  typedef enum logic [1:0] {
    ARP_ST_IDLE,
    ARP_ST_RUN,
    ARP_ST_CORR
  } arp_state_t;

endpackage

//--- test_arp_adc_post.sv
`timescale 1ns/1ps
module test_arp_adc_post
  import arp_pkg::*;
;
  logic ref_clk = 1'b0; // 10 MHz
  logic rst = 1'b1; // held at start
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, d;
  arp_sample_t sample_in;
  logic [1:0] start_evt = 2'h0;
  logic [1:0] flush_evt = 2'h0;
  logic conv_req, result_ready_evt, window_match_evt, irq;
  logic [11:0] val = 12'h000; // front end answer
  int err_count = 0;
  int num_checks = 0;
  int n, lat, lat0, e;
  int code_l[6] = '{1, 2, 5, 6, 8, 10};
  int adj_l[6] = '{1, 1, 4, 1, 0, 4};
  int vals[2] = '{384, 80};
  always #50 ref_clk = ~ref_clk;
  arp_adc_post arp_adc_post_i (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in),
    .start_evt(start_evt), .flush_evt(flush_evt), .conv_req(conv_req),
    .result_ready_evt(result_ready_evt),
    .window_match_evt(window_match_evt), .irq(irq));
  arp_front_model arp_front_model_i (.ref_clk(ref_clk), .rst(rst),
    .conv_req(conv_req), .val(val), .sample_in(sample_in));
  // ------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // data taken in the one cycle after the strobe
  task rdchk(input logic [7:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d, x);
  endtask
  // software start, counts requests until the ready event
  task run(output int c, output int t);
    wr(ARP_OFS_SWTRIG, 16'h0002);
    c = 0;
    for (t = 0; t < 8000; t++) begin
      #1;
      if (conv_req === 1'b1) c++;
      if (result_ready_evt === 1'b1) break;
      @(posedge ref_clk);
    end
    if (t == 8000) begin
      err_count++;
      $display("Error %0t: no result", $time);
      results();
    end
  endtask
  // event pulse, then requests counted over 20 cycles
  task ev_cnt(input logic [1:0] s, input logic [1:0] f, output int c);
    @(posedge ref_clk);
    start_evt <= s;
    flush_evt <= f;
    @(posedge ref_clk);
    start_evt <= 2'h0;
    flush_evt <= 2'h0;
    c = 0;
    repeat (20) begin
      #1;
      if (conv_req === 1'b1) c++;
      @(posedge ref_clk);
    end
  endtask
  // thresholds compared as plain integers of the right sign
  function automatic logic win_f(input int m, x, lo, hi);
    case (m)
      1: return x > lo;
      2: return x < hi;
      3: return x > lo && x < hi;
      default: return !(x > lo && x < hi);
    endcase
  endfunction
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(ARP_OFS_SECOND_CONTROL, 16'h0000);
    rdchk(ARP_OFS_GAIN, 16'h0800);
    rdchk(ARP_OFS_IFLAG, 16'h0000);
    $display("test reset done");
    val = 12'h123;
    wr(ARP_OFS_EVENT_CONTROL, 16'h0030);
    wr(ARP_OFS_IENSET, 16'h0001);
    run(n, lat0);
    chk(16'(n), 16'h0001);
    rdchk(ARP_OFS_RESULT, 16'h0123);
    chk(16'(irq), 16'h0001);
    wr(ARP_OFS_IFLAG, 16'h0007);
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(irq), 16'h0000);
    run(n, lat);
    run(n, lat);
    rdchk(ARP_OFS_IFLAG, 16'h0003);
    wr(ARP_OFS_IENCLR, 16'h0007);
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(irq), 16'h0000);
    rdchk(ARP_OFS_IENSET, 16'h0000);
    wr(ARP_OFS_IFLAG, 16'h0007);
    $display("test interrupt done");
    val = 12'h9A7;
    wr(ARP_OFS_SECOND_CONTROL, 16'h0010);
    for (int i = 0; i < 6; i++) begin
      wr(ARP_OFS_AVG, 16'((adj_l[i] << 4) | code_l[i]));
      run(n, lat);
      chk(16'(n), 16'(1 << code_l[i]));
      e = (int'(val) << code_l[i]) >>
        ((code_l[i] > 4 ? code_l[i] - 4 : 0) + adj_l[i]);
      rdchk(ARP_OFS_RESULT, 16'(e));
    end
    $display("test averaging done");
    wr(ARP_OFS_AVG, 16'h0000);
    wr(ARP_OFS_SECOND_CONTROL, 16'h0000);
    wr(ARP_OFS_WINDOW_LOWER_THRESHOLD, 16'h0100);
    wr(ARP_OFS_WINDOW_UPPER_THRESHOLD, 16'h0200);
    for (int j = 0; j < 2; j++) begin
      for (int m = 1; m < 5; m++) begin
        val = 12'(vals[j]);
        wr(ARP_OFS_WIN, 16'(m));
        wr(ARP_OFS_IFLAG, 16'h0007);
        run(n, lat);
        chk(16'(window_match_evt), 16'(win_f(m, vals[j], 256, 512)));
        rdchk(ARP_OFS_IFLAG, 16'h0001 | 16'(win_f(m, vals[j], 256, 512)) << 2
          | 16'(m > 1 || j > 0) << 1);
      end
    end
    wr(ARP_OFS_SECOND_CONTROL, 16'h0001);
    wr(ARP_OFS_WINDOW_LOWER_THRESHOLD, 16'hFF00);
    wr(ARP_OFS_WIN, 16'h0001);
    val = 12'h010;
    run(n, lat);
    chk(16'(window_match_evt), 16'h0001);
    $display("test window done");
    wr(ARP_OFS_WIN, 16'h0000);
    wr(ARP_OFS_SECOND_CONTROL, 16'h0000);
    wr(ARP_OFS_OFFS, 16'h0010);
    wr(ARP_OFS_GAIN, 16'h0400);
    val = 12'h120;
    run(n, lat0);
    rdchk(ARP_OFS_RESULT, 16'h0120);
    wr(ARP_OFS_SECOND_CONTROL, 16'h0008);
    run(n, lat);
    rdchk(ARP_OFS_RESULT, 16'h0088);
    chk(16'(lat - lat0), 16'h000D);
    wr(ARP_OFS_SECOND_CONTROL, 16'h0000);
    $display("test correction done");
    ev_cnt(2'h2, 2'h0, n);
    chk(16'(n), 16'h0000);
    wr(ARP_OFS_EVENT_CONTROL, 16'h0033);
    ev_cnt(2'h1, 2'h0, n);
    chk(16'(n), 16'h0001);
    ev_cnt(2'h2, 2'h0, n);
    chk(16'(n), 16'h0001);
    wr(ARP_OFS_SECOND_CONTROL, 16'h0010);
    wr(ARP_OFS_AVG, 16'h0002);
    wr(ARP_OFS_IFLAG, 16'h0007);
    val = 12'h200;
    wr(ARP_OFS_SWTRIG, 16'h0002);
    repeat (13) @(posedge ref_clk);
    ev_cnt(2'h0, 2'h2, n);
    chk(16'(n), 16'h0000);
    rdchk(ARP_OFS_IFLAG, 16'h0000);
    val = 12'h100;
    run(n, lat);
    chk(16'(n), 16'h0004);
    rdchk(ARP_OFS_RESULT, 16'h0400);
    wr(ARP_OFS_SWTRIG, 16'h0001);
    repeat (8) @(posedge ref_clk);
    $display("test events done");
    results();
  end
endmodule
